// ---- design/ssx_exec.sv ----
// Executes halt, subtract-accumulator-from-file and nibble exchange.
// Assumes an APB master on i_clk; file bank of 32 bytes kept locally.
//
// How it works
// - Halt opcode 003h stops the clock output and enters halt state.
// - Halt sets timeout flag, clears powerdown flag, keeps other flags.
// - Halt clears the watchdog counter and its prescaler.
// - Subtract opcode: file register minus accumulator, two's complement.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Subtract updates carry, digit carry, zero; carry one means no borrow.
// - Nibble exchange opcode swaps nibbles, leaves all flags alone.
// - Destination bit picks accumulator or source file register.
`timescale 1ns/1ps
module ssx_exec #(
  parameter int WDOG_W = 8,
  parameter int PRE_W  = 8
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Core status
  output logic             o_osc_run,
  output logic             o_halted
);
  logic [7:0]        acc;
  logic [7:0]        status;
  logic [7:0]        file_bank [32];
  logic [4:0]        file_ptr;
  logic [WDOG_W-1:0] watchdog_counter;
  logic [PRE_W-1:0]  wdog_pre;
  logic [31:0]       prdata;

  // Bus decode
  wire apb_acc = i_psel && i_penable;
  wire apb_wr  = apb_acc && i_pwrite;
  wire wr_ctrl  = apb_wr && (i_paddr == ssx_pkg::ADDR_CTRL);
  wire wr_instr = apb_wr && (i_paddr == ssx_pkg::ADDR_INSTR);
  wire wr_acc   = apb_wr && (i_paddr == ssx_pkg::ADDR_ACC);
  wire wr_stat  = apb_wr && (i_paddr == ssx_pkg::ADDR_STATUS);
  wire wr_file  = apb_wr && (i_paddr == ssx_pkg::ADDR_FILE);
  wire mapped   = (i_paddr == ssx_pkg::ADDR_CTRL) || (i_paddr == ssx_pkg::ADDR_INSTR) ||
                  (i_paddr == ssx_pkg::ADDR_ACC) || (i_paddr == ssx_pkg::ADDR_STATUS) ||
                  (i_paddr == ssx_pkg::ADDR_FILE) || (i_paddr == ssx_pkg::ADDR_WDOG);
  wire halted   = status[ssx_pkg::ST_HALT];

  // Opcode classify
  function automatic ssx_pkg::ssx_op_e classify(input logic [11:0] ins);
    if (ins == ssx_pkg::OP_HALT)
      return ssx_pkg::SSX_HALT;
    else if ((ins & ssx_pkg::MASK_FD) == ssx_pkg::OP_SUB)
      return ssx_pkg::SSX_SUB;
    else if ((ins & ssx_pkg::MASK_FD) == ssx_pkg::OP_SWAP)
      return ssx_pkg::SSX_SWAP;
    else
      return ssx_pkg::SSX_NONE;
  endfunction

  wire [11:0]           ins    = i_pwdata[11:0];
  // Instructions are refused while halted; a control write wakes the core
  wire ssx_pkg::ssx_op_e op     = (wr_instr && !halted) ? classify(ins) : ssx_pkg::SSX_NONE;
  wire [4:0]            f_addr = ins[ssx_pkg::ADDR_LSB +: ssx_pkg::AW];
  wire                  dest   = ins[ssx_pkg::DEST_BIT];
  wire [7:0]            f_val  = file_bank[f_addr];

  wire [8:0] diff9  = {1'b0, f_val} + {1'b0, ~acc} + 9'h001;
  wire [4:0] diff5  = {1'b0, f_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire [7:0] diff   = diff9[7:0];
  wire [7:0] swapped = {f_val[3:0], f_val[7:4]};
  wire       is_sub  = (op == ssx_pkg::SSX_SUB);
  wire       is_swap = (op == ssx_pkg::SSX_SWAP);
  wire [7:0] result  = is_sub ? diff : swapped;

  ssx_pkg::ssx_fwr_s fwr;
  assign fwr.wr_en = ((is_sub || is_swap) && dest) || wr_file;
  assign fwr.addr  = wr_file ? file_ptr : f_addr;
  assign fwr.data  = wr_file ? i_pwdata[7:0] : result;
  wire acc_from_op = (is_sub || is_swap) && !dest;

  // Next status
  logic [7:0] next_status;
  always_comb begin
    next_status = status;
    if (wr_stat)
      next_status = i_pwdata[7:0];
    if (wr_ctrl)
      next_status[ssx_pkg::ST_HALT] = 1'b0;
    if (op == ssx_pkg::SSX_HALT) begin
      next_status[ssx_pkg::ST_TO]   = 1'b1;
      next_status[ssx_pkg::ST_PD]   = 1'b0;
      next_status[ssx_pkg::ST_HALT] = 1'b1;
    end
    if (is_sub) begin
      next_status[ssx_pkg::ST_C]  = diff9[8];
      next_status[ssx_pkg::ST_DC] = diff5[4];
      next_status[ssx_pkg::ST_Z]  = (diff == ssx_pkg::ZERO8);
    end
  end

  // Status and accumulator
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      status <= ssx_pkg::STATUS_RST;
      acc    <= ssx_pkg::ZERO8;
    end else begin
      status <= next_status;
      if (acc_from_op)
        acc <= result;
      else if (wr_acc)
        acc <= i_pwdata[7:0];
    end
  end

  // File bank write port
  always_ff @(posedge i_clk) begin
    if (fwr.wr_en)
      file_bank[fwr.addr] <= fwr.data;
  end

  // File pointer from control writes
  always_ff @(posedge i_clk) begin
    if (i_srst)
      file_ptr <= '0;
    else if (wr_ctrl)
      file_ptr <= i_pwdata[12:8];
  end

  // Watchdog: runs while awake, cleared by halt
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      watchdog_counter <= '0;
      wdog_pre         <= '0;
    end else if (op == ssx_pkg::SSX_HALT) begin
      watchdog_counter <= '0;
      wdog_pre         <= '0;
    end else if (!halted) begin
      wdog_pre <= wdog_pre + PRE_W'(1);
      if (&wdog_pre)
        watchdog_counter <= watchdog_counter + WDOG_W'(1);
    end
  end

  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    case (i_paddr)
      ssx_pkg::ADDR_CTRL:   prdata[12:8] = file_ptr;
      ssx_pkg::ADDR_ACC:    prdata[7:0]  = acc;
      ssx_pkg::ADDR_STATUS: prdata[7:0]  = status;
      ssx_pkg::ADDR_FILE:   prdata[7:0]  = file_bank[file_ptr];
      ssx_pkg::ADDR_WDOG:   prdata[WDOG_W-1:0] = watchdog_counter;
      default:              prdata = 32'h0000_0000;
    endcase
  end

  // Registered read data
  always_ff @(posedge i_clk) begin
    if (i_srst)
      o_prdata <= 32'h0000_0000;
    else if (i_psel && !i_penable && !i_pwrite)
      o_prdata <= prdata;
  end

  // Bus answer: no wait states, error on unmapped offsets
  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc && !mapped;
  assign o_osc_run = !halted;
  assign o_halted  = halted;

  // Checks below run on i_clk and stay quiet during reset
  // Results are compared one cycle after the op, against sampled operands
  // Halt accepted this cycle
  sequence s_halt_issued;
    op == ssx_pkg::SSX_HALT;
  endsequence

  // Halt state with both flags settled and clock output off
  sequence s_halt_state;
    status[ssx_pkg::ST_TO] && !status[ssx_pkg::ST_PD] && halted && !o_osc_run;
  endsequence

  // Subtract accepted this cycle
  sequence s_sub_issued;
    is_sub;
  endsequence

  // Nibble exchange accepted this cycle
  sequence s_swap_issued;
    is_swap;
  endsequence

  a_halt_flags: assert property (@(posedge i_clk) disable iff (i_srst)
    s_halt_issued |=> status[ssx_pkg::ST_TO] && !status[ssx_pkg::ST_PD]
      && !o_osc_run && $stable(status[2:0]))
    else $error("halt flags wrong");

  a_halt_enter: assert property (@(posedge i_clk) disable iff (i_srst)
    s_halt_issued |=> s_halt_state)
    else $error("halt state not entered");

  a_halt_refuse: assert property (@(posedge i_clk) disable iff (i_srst)
    (halted && wr_instr)
      |=> $stable(acc) && $stable(status))
    else $error("instruction ran while halted");

  a_halt_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    (halted && !wr_ctrl && !wr_stat) |=> halted)
    else $error("halt left without wake");

  a_wdog_clear: assert property (@(posedge i_clk) disable iff (i_srst)
    s_halt_issued |=> watchdog_counter == '0 && wdog_pre == '0)
    else $error("watchdog not cleared");

  a_sub_carry: assert property (@(posedge i_clk) disable iff (i_srst)
    s_sub_issued |=> status[ssx_pkg::ST_C] == ($past(f_val) >= $past(acc)))
    else $error("carry wrong");

  a_sub_zero: assert property (@(posedge i_clk) disable iff (i_srst)
    s_sub_issued |=> status[ssx_pkg::ST_Z] == ($past(f_val) == $past(acc)))
    else $error("zero flag wrong");

  a_sub_digit: assert property (@(posedge i_clk) disable iff (i_srst)
    s_sub_issued |=> status[ssx_pkg::ST_DC] == ($past(f_val[3:0]) >= $past(acc[3:0])))
    else $error("digit carry wrong");

  a_sub_upper: assert property (@(posedge i_clk) disable iff (i_srst)
    s_sub_issued |=> $stable(status[7:3]))
    else $error("subtract changed other flags");

  a_sub_to_acc: assert property (@(posedge i_clk) disable iff (i_srst)
    (is_sub && !dest) |=> acc == 8'($past(f_val) - $past(acc)))
    else $error("subtract to acc wrong");

  a_sub_to_file: assert property (@(posedge i_clk) disable iff (i_srst)
    (is_sub && dest)
      |=> file_bank[$past(f_addr)] == 8'($past(f_val) - $past(acc)))
    else $error("subtract to file wrong");

  // Accumulator kept when file is the target
  a_sub_acc_keep: assert property (@(posedge i_clk) disable iff (i_srst)
    (is_sub && dest) |=> $stable(acc))
    else $error("subtract disturbed acc");

  // File kept when accumulator is the target
  a_sub_file_keep: assert property (@(posedge i_clk) disable iff (i_srst)
    (is_sub && !dest)
      |=> file_bank[$past(f_addr)] == $past(f_val))
    else $error("subtract disturbed file");

  a_swap_flags: assert property (@(posedge i_clk) disable iff (i_srst)
    s_swap_issued |=> $stable(status))
    else $error("swap changed flags");

  a_swap_acc: assert property (@(posedge i_clk) disable iff (i_srst)
    (is_swap && !dest) |=> acc == {$past(f_val[3:0]), $past(f_val[7:4])})
    else $error("swap result wrong");

  a_swap_to_file: assert property (@(posedge i_clk) disable iff (i_srst)
    (is_swap && dest)
      |=> file_bank[$past(f_addr)] == {$past(f_val[3:0]), $past(f_val[7:4])})
    else $error("swap to file wrong");

  // Accumulator kept when file is the target
  a_swap_acc_keep: assert property (@(posedge i_clk) disable iff (i_srst)
    (is_swap && dest) |=> $stable(acc))
    else $error("swap disturbed acc");

  // Source kept when accumulator is the target
  a_swap_file_keep: assert property (@(posedge i_clk) disable iff (i_srst)
    (is_swap && !dest)
      |=> file_bank[$past(f_addr)] == $past(f_val))
    else $error("swap disturbed file");
endmodule // ssx_exec

// ---- design/ssx_pkg.sv ----
// Package for the halt/subtract/nibble-exchange execution block.
// Assumes a 12-bit instruction word and an 8-bit data path.
package ssx_pkg;
  localparam int IW = 12;
  localparam int DW = 8;
  localparam int AW = 5;
  // Opcodes and match masks
  localparam logic [11:0] OP_HALT     = 12'h003;
  localparam logic [11:0] OP_SUB      = 12'h080;
  localparam logic [11:0] OP_SWAP     = 12'h380;
  localparam logic [11:0] MASK_FULL   = 12'hfff;
  localparam logic [11:0] MASK_FD     = 12'hfc0;
  // Field positions
  localparam int DEST_BIT = 5;
  localparam int ADDR_LSB = 0;
  localparam int NIB      = 4;
  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INSTR  = 8'h04;
  localparam logic [7:0] ADDR_ACC    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_FILE   = 8'h10;
  localparam logic [7:0] ADDR_WDOG   = 8'h14;
  // Status bit positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_HALT = 5;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] ZERO8      = 8'h00;
  typedef struct packed {
    logic       wr_en;
    logic [4:0] addr;
    logic [7:0] data;
  } ssx_fwr_s;
  typedef enum logic [1:0] {SSX_NONE, SSX_HALT, SSX_SUB, SSX_SWAP} ssx_op_e;
endpackage

// ---- testbench/tb.sv ----
// Bench for the halt, subtract and nibble exchange block.
// Assumes a zero-wait APB slave; 8-bit data in the low byte.
`timescale 1ns/1ps
module tb;
  logic        i_clk = 0;
  logic        i_srst = 1;
  logic        i_psel = 0;
  logic        i_penable = 0;
  logic        i_pwrite = 0;
  logic [7:0]  i_paddr = '0;
  logic [31:0] i_pwdata = '0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_osc_run;
  logic        o_halted;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'd36957;
  logic [16:0] q[$];
  logic [16:0] ent;

  ssx_exec ssx_exec_inst (.i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_osc_run(o_osc_run), .o_halted(o_halted));

  // Clock, 25 ns period
  always #12.5 i_clk = ~i_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic stop_test();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; holds until pready, then idles one cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [7:0] a, m, e, input logic er);
    q.push_back({er, m, e & m});
    xfer(0, a, 32'h0);
  endtask

  // Read monitor: compares against the oldest note
  always @(posedge i_clk) begin
    if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
      ent = q.pop_front();
      chk("prdata", o_prdata[7:0] & ent[15:8], ent[7:0]);
      chk("pslverr", {7'h0, o_pslverr}, {7'h0, ent[16]});
    end
  end

  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    logic [7:0] f, w, r, st;
    logic [4:0] a;
    logic       d;
    repeat (3) @(posedge i_clk);
    i_srst <= 0;
    @(posedge i_clk);
    rd(ssx_pkg::ADDR_STATUS, 8'h3f, 8'h18, 0);
    for (int i = 0; i < 16; i++) begin
      d = i[0];
      a = 5'(rnd());
      f = 8'(rnd());
      w = (i == 4) ? f : 8'(rnd());
      st = 8'(rnd()) & 8'h07;
      xfer(1, ssx_pkg::ADDR_CTRL, {19'h0, a, 8'h0});
      xfer(1, ssx_pkg::ADDR_FILE, {24'h0, f});
      xfer(1, ssx_pkg::ADDR_ACC, {24'h0, w});
      xfer(1, ssx_pkg::ADDR_STATUS, {24'h0, st | 8'h18});
      if (i[1]) begin
        r = {f[3:0], f[7:4]};
        xfer(1, ssx_pkg::ADDR_INSTR, {20'h0, ssx_pkg::OP_SWAP | {6'h0, d, a}});
      end else begin
        r = f - w;
        st = {5'h0, r == 8'h00, f[3:0] >= w[3:0], f >= w};
        xfer(1, ssx_pkg::ADDR_INSTR, {20'h0, ssx_pkg::OP_SUB | {6'h0, d, a}});
      end
      rd(ssx_pkg::ADDR_ACC, 8'hff, d ? w : r, 0);
      rd(ssx_pkg::ADDR_FILE, 8'hff, d ? r : f, 0);
      rd(ssx_pkg::ADDR_STATUS, 8'h07, st, 0);
    end
    // Let the watchdog run, then halt
    xfer(1, ssx_pkg::ADDR_STATUS, 32'h03);
    repeat (600) @(posedge i_clk);
    xfer(1, ssx_pkg::ADDR_INSTR, {20'h0, ssx_pkg::OP_HALT});
    chk("halted", {7'h0, o_halted}, 8'h01);
    chk("osc_run", {7'h0, o_osc_run}, 8'h00);
    rd(ssx_pkg::ADDR_WDOG, 8'hff, 8'h00, 0);
    rd(ssx_pkg::ADDR_STATUS, 8'h3f, 8'h33, 0);
    xfer(1, ssx_pkg::ADDR_ACC, 32'h5a);
    xfer(1, ssx_pkg::ADDR_INSTR, {20'h0, ssx_pkg::OP_SWAP});
    rd(ssx_pkg::ADDR_ACC, 8'hff, 8'h5a, 0);
    xfer(1, ssx_pkg::ADDR_CTRL, 32'h0);
    chk("halted", {7'h0, o_halted}, 8'h00);
    // Prescaler restarts from zero, so the first tick comes 256 cycles after wake
    repeat (240) @(posedge i_clk);
    rd(ssx_pkg::ADDR_WDOG, 8'hff, 8'h00, 0);
    repeat (20) @(posedge i_clk);
    rd(ssx_pkg::ADDR_WDOG, 8'hff, 8'h01, 0);
    rd(8'h18, 8'h00, 8'h00, 1);
    stop_test();
  end
endmodule // tb
